//--- rtl/lpmn_ds_negotiator.sv
// downstream-end entry negotiation for l1 and l2/l3 ready
// assumes link layer gives one-cycle strobes, all sync to mclk
// assumes the far end answers a taken entry dllp with ack, nak or nothing
`timescale 1ns/1ps
`include "lpmn_regs.svh"
module lpmn_ds_negotiator #(
	parameter int unsigned RESEND_CYC = `LPMN_RESEND_CYC
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// entry requests
	input wire logic l1_sw_req,
	input wire logic l1_aspm_req,
	input wire logic pme_to_ack_sent,
	// link status
	input wire logic link_interrupt,
	input wire logic link_down,
	input wire logic partner_ack,
	input wire logic partner_nak,
	// entry dllp transmit
	output logic dllp_tx_valid,
	output logic [1:0] dllp_tx_type,
	input wire logic dllp_tx_ready,
	// results
	output logic busy,
	output logic enter_l1,
	output logic enter_l23,
	output logic done_pulse,
	output logic abort_pulse
);
	// ==========================================
	// state
	lpmn_pkg::lpmn_state_e state_ff, nxt_state;
	lpmn_pkg::lpmn_kind_e kind_ff, nxt_kind;
	logic restart_ff, nxt_restart;
	logic done_ff, nxt_done;
	logic abort_ff, nxt_abort;
	logic l1_ff, nxt_l1;
	logic l23_ff, nxt_l23;
	logic tx_valid_ff, nxt_tx_valid;
	logic [1:0] tx_type_ff, nxt_tx_type;
	logic ev_done, ev_abort, ev_clear;
	lpmn_tmr_if tif ();

	function automatic logic [1:0] kind_code(input lpmn_pkg::lpmn_kind_e k);
		case (k)
			lpmn_pkg::LPMN_KIND_L1: kind_code = `LPMN_DLLP_L1;
			lpmn_pkg::LPMN_KIND_L23: kind_code = `LPMN_DLLP_L23;
			default: kind_code = `LPMN_DLLP_NONE;
		endcase
	endfunction

	// true while the link must be held in l0
	function automatic logic in_flight(input lpmn_pkg::lpmn_state_e s);
		in_flight = (s == lpmn_pkg::LPMN_SEND) || (s == lpmn_pkg::LPMN_WAIT_ACK);
	endfunction

	// one timer suffices: only one negotiation is ever in flight
	lpmn_timer #(.CYCLES(RESEND_CYC)) u_timer (
		.mclk(mclk),
		.rst(rst),
		.tmr(tif.tmr)
	);

	// ==========================================
	// next state
	always_comb begin
		nxt_state = state_ff;
		nxt_kind = kind_ff;
		nxt_restart = restart_ff;
		nxt_tx_valid = 1'b0;
		nxt_tx_type = `LPMN_DLLP_NONE;
		tif.start = 1'b0;
		ev_done = 1'b0;
		ev_abort = 1'b0;
		// l-state held only until link goes down or, in done, is interrupted
		ev_clear = link_down;
		if ((link_interrupt || link_down) && in_flight(state_ff)) begin
			nxt_state = lpmn_pkg::LPMN_IDLE;
			ev_abort = 1'b1;
			// remember to restart, not after link down
			nxt_restart = !link_down;
		end else begin
			case (state_ff)
				lpmn_pkg::LPMN_IDLE: begin
					// no start on a downed link; the host asks again later
					if (link_down) begin
						nxt_restart = 1'b0;
					// pme ack starts l2/l3 ready entry
					end else if (pme_to_ack_sent) begin
						nxt_kind = lpmn_pkg::LPMN_KIND_L23;
						nxt_state = lpmn_pkg::LPMN_SEND;
					// sw and aspm share one machine
					end else if (l1_sw_req || l1_aspm_req) begin
						nxt_kind = lpmn_pkg::LPMN_KIND_L1;
						nxt_state = lpmn_pkg::LPMN_SEND;
					end else if (restart_ff && kind_ff != lpmn_pkg::LPMN_KIND_NONE) begin
						nxt_state = lpmn_pkg::LPMN_SEND;
					end
					if (nxt_state == lpmn_pkg::LPMN_SEND) begin
						nxt_restart = 1'b0;
					end
				end
				lpmn_pkg::LPMN_SEND: begin
					nxt_tx_valid = 1'b1;
					nxt_tx_type = kind_code(kind_ff);
					if (tx_valid_ff && dllp_tx_ready) begin
						nxt_tx_valid = 1'b0;
						nxt_tx_type = `LPMN_DLLP_NONE;
						tif.start = 1'b1;
						nxt_state = lpmn_pkg::LPMN_WAIT_ACK;
					end
				end
				lpmn_pkg::LPMN_WAIT_ACK: begin
					if (partner_ack) begin
						nxt_state = lpmn_pkg::LPMN_DONE;
						ev_done = 1'b1;
					end else if (partner_nak) begin
						nxt_state = lpmn_pkg::LPMN_IDLE;
						ev_abort = 1'b1;
						nxt_kind = lpmn_pkg::LPMN_KIND_NONE;
					end else if (tif.expired) begin
						// keep repeating entry dllps until answered
						nxt_state = lpmn_pkg::LPMN_SEND;
					end
				end
				lpmn_pkg::LPMN_DONE: begin
					// wait for the link to leave the l-state, then rearm
					if (link_interrupt || link_down) begin
						nxt_state = lpmn_pkg::LPMN_IDLE;
						nxt_kind = lpmn_pkg::LPMN_KIND_NONE;
						ev_clear = 1'b1;
					end
				end
				default: begin
					nxt_state = lpmn_pkg::LPMN_IDLE;
				end
			endcase
		end
	end

	// ==========================================
	// result flags
	always_comb begin
		nxt_done = ev_done;
		nxt_abort = ev_abort;
		nxt_l1 = l1_ff;
		nxt_l23 = l23_ff;
		// levels rise with the done pulse
		if (ev_clear) begin
			nxt_l1 = 1'b0;
			nxt_l23 = 1'b0;
		end else if (ev_done) begin
			nxt_l1 = (kind_ff == lpmn_pkg::LPMN_KIND_L1);
			nxt_l23 = (kind_ff == lpmn_pkg::LPMN_KIND_L23);
		end
	end

	// ==========================================
	// negotiation registers
	// reset lands in idle
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state_ff <= lpmn_pkg::LPMN_IDLE;
			kind_ff <= lpmn_pkg::LPMN_KIND_NONE;
			restart_ff <= 1'b0;
			tx_valid_ff <= 1'b0;
			tx_type_ff <= `LPMN_DLLP_NONE;
		end else begin
			state_ff <= nxt_state;
			kind_ff <= nxt_kind;
			restart_ff <= nxt_restart;
			tx_valid_ff <= nxt_tx_valid;
			tx_type_ff <= nxt_tx_type;
		end
	end

	// ==========================================
	// result registers
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			done_ff <= 1'b0;
			abort_ff <= 1'b0;
			l1_ff <= 1'b0;
			l23_ff <= 1'b0;
		end else begin
			done_ff <= nxt_done;
			abort_ff <= nxt_abort;
			l1_ff <= nxt_l1;
			l23_ff <= nxt_l23;
		end
	end

	// ==========================================
	// outputs
	assign dllp_tx_valid = tx_valid_ff;
	assign dllp_tx_type = tx_type_ff;
	assign busy = in_flight(state_ff);
	assign enter_l1 = l1_ff;
	assign enter_l23 = l23_ff;
	assign done_pulse = done_ff;
	assign abort_pulse = abort_ff;
endmodule

//--- common/lpmn_regs.svh
// constants for the link power-state entry negotiation block
// assumes one 20 mhz link-layer clock
`ifndef LPMN_REGS_SVH
`define LPMN_REGS_SVH
// ==========================================
// timing
`define LPMN_CLK_PERIOD_NS 50
`define LPMN_RESEND_NS 1000
`define LPMN_RESEND_CYC ((`LPMN_RESEND_NS + `LPMN_CLK_PERIOD_NS - 1) / `LPMN_CLK_PERIOD_NS)
// ==========================================
// entry dllp codes on the tx port
`define LPMN_DLLP_NONE 2'h0
`define LPMN_DLLP_L1 2'h1
`define LPMN_DLLP_L23 2'h2
`endif

//--- common/lpmn_pkg.sv
// types for the link power-state entry negotiation block
// assumes nothing of its surroundings
package lpmn_pkg;
	typedef enum logic [1:0] {
		LPMN_KIND_NONE,
		LPMN_KIND_L1,
		LPMN_KIND_L23
	} lpmn_kind_e;
	typedef enum logic [1:0] {
		LPMN_IDLE,
		LPMN_SEND,
		LPMN_WAIT_ACK,
		LPMN_DONE
	} lpmn_state_e;
endpackage

//--- common/lpmn_tmr_if.sv
// carrier between the negotiation fsm and its resend timer
// assumes a single clock domain
`timescale 1ns/1ps
interface lpmn_tmr_if;
	logic start;
	logic expired;
	modport fsm (output start, input expired);
	modport tmr (input start, output expired);
endinterface

//--- rtl/lpmn_timer.sv
// resend interval timer for entry dllp repetition
// assumes mclk and async active-high rst
`timescale 1ns/1ps
`include "lpmn_regs.svh"
module lpmn_timer #(
	parameter int unsigned CYCLES = `LPMN_RESEND_CYC
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// control
	lpmn_tmr_if.tmr tmr
);
	localparam int unsigned W = $clog2(CYCLES + 1);
	logic [W-1:0] cnt_ff, nxt_cnt;
	always_comb begin
		if (tmr.start) begin
			nxt_cnt = W'(CYCLES - 1);
		end else if (cnt_ff != '0) begin
			nxt_cnt = cnt_ff - 1'b1;
		end else begin
			nxt_cnt = cnt_ff;
		end
	end
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cnt_ff <= '0;
		end else begin
			cnt_ff <= nxt_cnt;
		end
	end
	assign tmr.expired = (cnt_ff == W'(1)) && !tmr.start;
endmodule

//--- verif/lpmn_ds_negotiator_assertions.sv
// port checker for the downstream entry negotiation fsm
// assumes it is bound onto lpmn_ds_negotiator
`timescale 1ns/1ps
`include "lpmn_regs.svh"
module lpmn_ds_negotiator_assertions (
	// clock, reset and requests
	input wire logic mclk,
	input wire logic rst,
	input wire logic l1_sw_req,
	input wire logic l1_aspm_req,
	input wire logic pme_to_ack_sent,
	// link side
	input wire logic link_interrupt,
	input wire logic link_down,
	input wire logic partner_ack,
	input wire logic dllp_tx_ready,
	input wire logic dllp_tx_valid,
	input wire logic [1:0] dllp_tx_type,
	// results
	input wire logic busy,
	input wire logic enter_l1,
	input wire logic enter_l23,
	input wire logic done_pulse,
	input wire logic abort_pulse
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	// ====
	// idle is the only state with busy and both levels low
	logic go;
	assign go = !busy && !enter_l1 && !enter_l23 && !link_interrupt && !link_down;
	property p_rst; $fell(rst) |-> !busy && !dllp_tx_valid && !enter_l1 && !enter_l23; endproperty
	a_rst: assert property (p_rst) else $error("outputs set after reset");
	property p_l1; go && (l1_sw_req || l1_aspm_req) && !pme_to_ack_sent
		|=> busy ##1 dllp_tx_valid && dllp_tx_type == `LPMN_DLLP_L1; endproperty
	a_l1: assert property (p_l1) else $error("no l1 entry dllp");
	property p_l23; go && pme_to_ack_sent
		|=> busy ##1 dllp_tx_valid && dllp_tx_type == `LPMN_DLLP_L23; endproperty
	a_l23: assert property (p_l23) else $error("no l23 entry dllp");
	property p_abort; busy && (link_interrupt || link_down) |=> abort_pulse && !busy; endproperty
	a_abort: assert property (p_abort) else $error("no abort");
	property p_restart; busy && link_interrupt && !link_down |=> ##[1:3] dllp_tx_valid; endproperty
	a_restart: assert property (p_restart) else $error("no restart");
	property p_hold; dllp_tx_valid && !dllp_tx_ready && !link_interrupt && !link_down
		|=> dllp_tx_valid && $stable(dllp_tx_type); endproperty
	a_hold: assert property (p_hold) else $error("dllp dropped");
	property p_done; done_pulse |-> $past(partner_ack) && !busy && (enter_l1 || enter_l23); endproperty
	a_done: assert property (p_done) else $error("early done");
	property p_l0; busy |-> !enter_l1 && !enter_l23; endproperty
	a_l0: assert property (p_l0) else $error("state entered while busy");
	property p_clear; link_down |=> !enter_l1 && !enter_l23; endproperty
	a_clear: assert property (p_clear) else $error("level kept after link down");
	c_l1: cover property (done_pulse && enter_l1);
	c_l23: cover property (done_pulse && enter_l23);
	c_abort: cover property (abort_pulse);
endmodule
bind lpmn_ds_negotiator lpmn_ds_negotiator_assertions i_lpmn_ds_negotiator_assertions (.mclk,
	.rst, .l1_sw_req, .l1_aspm_req, .pme_to_ack_sent, .link_interrupt, .link_down, .partner_ack,
	.dllp_tx_ready, .dllp_tx_valid, .dllp_tx_type, .busy, .enter_l1, .enter_l23, .done_pulse,
	.abort_pulse);

//--- verif/lpmn_partner.sv
// link partner model: takes entry dllps, answers ack, nak or nothing
// assumes the bench sets mode (0 ack, 1 nak, 2 silent) and stall
`timescale 1ns/1ps
module lpmn_partner (
	// clock, reset and behaviour
	input wire logic mclk,
	input wire logic rst,
	input wire logic [1:0] mode,
	input wire logic [3:0] stall,
	// link side
	input wire logic dllp_tx_valid,
	output logic dllp_tx_ready,
	output logic partner_ack,
	output logic partner_nak
);
	initial begin
		{dllp_tx_ready, partner_ack, partner_nak} = 3'h0;
		forever begin
			@(posedge mclk);
			#1 {dllp_tx_ready, partner_ack, partner_nak} = 3'h0;
			if (!rst && dllp_tx_valid) begin
				repeat (stall) @(posedge mclk);
				#1 dllp_tx_ready = 1'b1;
				@(posedge mclk);
				#1 dllp_tx_ready = 1'b0;
				repeat (stall) @(posedge mclk);
				#1 partner_ack = mode == 2'h0;
				partner_nak = mode == 2'h1;
			end
		end
	end
endmodule

//--- verif/tb_link_pm_entry_negotiation.sv
// self-checking bench for the downstream entry negotiation fsm
// assumes the partner model on the far side
`timescale 1ns/1ps
module tb_link_pm_entry_negotiation;
	logic mclk, rst, l1_sw_req, l1_aspm_req, pme_to_ack_sent, link_interrupt, link_down;
	logic partner_ack, partner_nak, dllp_tx_valid, dllp_tx_ready, busy, enter_l1, enter_l23;
	logic done_pulse, abort_pulse, hs;
	logic [1:0] dllp_tx_type, mode;
	logic [3:0] stall;
	logic [4:0] exp_q[$];
	int failures = 0;
	int tests_run = 0;
	// resend kept longer than the partner's slowest answer
	lpmn_ds_negotiator #(.RESEND_CYC(12)) i_lpmn_ds_negotiator (.mclk, .rst, .l1_sw_req,
		.l1_aspm_req, .pme_to_ack_sent, .link_interrupt, .link_down, .partner_ack, .partner_nak,
		.dllp_tx_valid, .dllp_tx_type, .dllp_tx_ready, .busy, .enter_l1, .enter_l23,
		.done_pulse, .abort_pulse);
	lpmn_partner i_lpmn_partner (.mclk, .rst, .mode, .stall, .dllp_tx_valid, .dllp_tx_ready,
		.partner_ack, .partner_nak);
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	task automatic chk(input logic [4:0] seen, input logic [4:0] want);
		tests_run++;
		if (seen !== want) begin
			failures++;
			$display("Error at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask
	task automatic give_verdict;
		$display("compares %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// ====
	// monitor: 1_00_type per dllp taken, 0_abort_done_l23_l1 per result
	assign hs = dllp_tx_valid && dllp_tx_ready;
	always @(negedge mclk) begin
		if (!rst && (hs || done_pulse || abort_pulse)) begin
			chk(hs ? {3'h4, dllp_tx_type} : {1'b0, abort_pulse, done_pulse, enter_l23, enter_l1},
				exp_q.size() > 0 ? exp_q.pop_front() : 5'h1f);
		end
	end
	// request bits: pme, sw, aspm, interrupt, down
	task automatic pulse(input logic [4:0] req, input logic [1:0] m, input logic [3:0] s);
		mode = m;
		stall = s;
		{pme_to_ack_sent, l1_sw_req, l1_aspm_req, link_interrupt, link_down} = req;
		@(posedge mclk);
		#1 {pme_to_ack_sent, l1_sw_req, l1_aspm_req, link_interrupt, link_down} = 5'h00;
	endtask
	task automatic end_test(input string name);
		for (int i = 0; i < 200 && exp_q.size() > 0; i++) @(posedge mclk);
		repeat (16) @(posedge mclk);
		chk(5'(exp_q.size()), 5'h00);
		chk({4'h0, busy}, 5'h00);
		#1 rst = 1'b1;
		repeat (2) @(posedge mclk);
		#1 rst = 1'b0;
		$display("test %s done", name);
	endtask
	initial begin
		rst = 1'b1;
		mode = 2'h0;
		stall = 4'h0;
		{pme_to_ack_sent, l1_sw_req, l1_aspm_req, link_interrupt, link_down} = 5'h00;
		void'($urandom(32'h71a1_b9d0));
		repeat (16) @(posedge mclk);
		#1 rst = 1'b0;
		for (int k = 0; k < 4; k++) begin
			exp_q = '{5'h11, 5'h05};
			pulse(k[0] ? 5'h08 : 5'h04, 2'h0, 4'($urandom_range(3)));
			end_test("l1");
		end
		exp_q = '{5'h12, 5'h06};
		pulse(5'h18, 2'h0, 4'($urandom_range(3)));
		end_test("l23");
		exp_q = '{5'h11, 5'h08};
		pulse(5'h04, 2'h1, 4'h0);
		end_test("nak");
		exp_q = '{5'h08, 5'h12, 5'h06};
		pulse(5'h10, 2'h0, 4'h8);
		repeat (3) @(posedge mclk);
		#1 pulse(5'h02, 2'h0, 4'h8);
		end_test("interrupt");
		exp_q = '{5'h11, 5'h11, 5'h08};
		pulse(5'h08, 2'h2, 4'h0);
		for (int i = 0; i < 60 && exp_q.size() > 1; i++) @(posedge mclk);
		#1 pulse(5'h01, 2'h2, 4'h0);
		end_test("resend");
		give_verdict();
	end
	initial begin
		#(50 * 4000);
		failures++;
		give_verdict();
	end
endmodule
